// ---- bench/fesl_afe_model.sv ----
// analog front end model: cable loopback, energy and link pulse sources
`timescale 1ns/1ps
`default_nettype none
module fesl_afe_model (
    input wire logic core_clk_i,
    input wire fesl_pkg::fesl_mlt3_s tx_line_i,
    input wire logic energy_on_i,
    input wire logic pulse_on_i,
    output fesl_pkg::fesl_mlt3_s rx_line_o,
    output logic rx_energy_o,
    output logic rx_link_pulse_o
);
    // one cycle of cable delay, equalized levels as sent
    always_ff @(posedge core_clk_i) begin
        rx_line_o <= tx_line_i;
    end
    assign rx_energy_o = energy_on_i;
    assign rx_link_pulse_o = pulse_on_i;
endmodule : fesl_afe_model
`default_nettype wire

// ---- bench/fesl_line_code_sva.sv ----
// port-level assertion checker for the line-coding block
`timescale 1ns/1ps
`default_nettype none
module fesl_line_code_sva (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire fesl_pkg::fesl_mlt3_s tx_line_o,
    input wire logic rx_energy_i,
    input wire logic rx_link_pulse_i,
    input wire logic signal_detect_o,
    input wire fesl_pkg::fesl_sym_s rx_sym_o,
    input wire logic rx_sync_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // four quiet cycles between symbol strobes
    sequence s_gap;
        !rx_sym_o.valid [*4];
    endsequence
    a_detect_masked: assert property (rx_link_pulse_i |=> !signal_detect_o)
        else $error("signal detect raised by link pulse");
    a_detect_follows: assert property ($past(rst_n_i) && rx_energy_i && !rx_link_pulse_i
        |=> signal_detect_o) else $error("signal detect missing");
    a_rails_exclusive: assert property (!(tx_line_o.pos && tx_line_o.neg))
        else $error("both rails driven");
    a_no_rail_jump: assert property (tx_line_o.pos |=> !tx_line_o.neg)
        else $error("rail jump without zero level");
    a_sym_synced: assert property (rx_sym_o.valid |-> rx_sync_o)
        else $error("symbol while unsynced");
    a_sym_spacing: assert property (rx_sym_o.valid |=> s_gap)
        else $error("symbol strobes closer than five");
    a_sync_holds: assert property ($rose(rx_sync_o) |-> rx_sync_o [*8])
        else $error("sync dropped early");
    a_sync_symbols: assert property ($rose(rx_sync_o) |-> ##[0:5] rx_sym_o.valid)
        else $error("no symbol after sync");
endmodule : fesl_line_code_sva
`default_nettype wire

// ---- bench/fesl_line_code_tb_top.sv ----
// self-checking bench for the line-coding block
`timescale 1ns/1ps
`default_nettype none
module fesl_line_code_tb_top;
    import fesl_pkg::*;
    localparam int unsigned HOLD = 200;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] strap = 5'h00;
    logic tx_nrz = 1'b1;
    logic energy_on = 1'b0;
    logic pulse_on = 1'b0;
    fesl_mlt3_s tx_line;
    fesl_mlt3_s rx_line;
    fesl_sym_s sym;
    logic rx_energy, rx_pulse, sig_det, rx_sync, aligned;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    always #25 core_clk_i = ~core_clk_i;
    fesl_line_code #(.HOLD_CYC(HOLD)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .station_address_strap_i(strap), .tx_nrz_i(tx_nrz), .tx_line_o(tx_line),
        .rx_line_i(rx_line), .rx_energy_i(rx_energy), .rx_link_pulse_i(rx_pulse),
        .signal_detect_o(sig_det), .rx_sym_o(sym), .rx_sync_o(rx_sync),
        .rx_aligned_o(aligned));
    fesl_afe_model afe (.core_clk_i(core_clk_i), .tx_line_i(tx_line), .energy_on_i(energy_on),
        .pulse_on_i(pulse_on), .rx_line_o(rx_line), .rx_energy_o(rx_energy),
        .rx_link_pulse_o(rx_pulse));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic do_reset(input logic [4:0] s);
        rst_n_i = 1'b0;
        strap = s;
        repeat (10) @(negedge core_clk_i);
        rst_n_i = 1'b1;
    endtask : do_reset
    // bounded wait, so a stuck sync cannot hang the run
    task automatic wait_sync(input logic lvl, output int n);
        n = 0;
        while (rx_sync !== lvl && n < 600) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask : wait_sync
    // same idle stream under two straps must leave different line patterns
    task automatic t_seed();
        fesl_mlt3_s a[24];
        logic diff;
        diff = 1'b0;
        do_reset(5'h00);
        foreach (a[i]) begin
            @(negedge core_clk_i);
            a[i] = tx_line;
        end
        do_reset(5'h15);
        foreach (a[i]) begin
            @(negedge core_clk_i);
            diff |= (a[i] !== tx_line);
        end
        check("seed_split", 1, diff);
    endtask : t_seed
    task automatic t_detect();
        energy_on = 1'b1;
        pulse_on = 1'b1;
        repeat (3) @(negedge core_clk_i);
        check("detect_pulse", 0, sig_det);
        pulse_on = 1'b0;
        repeat (2) @(negedge core_clk_i);
        check("detect_energy", 1, sig_det);
    endtask : t_detect
    // acquire on idles, keep while idles flow, lose on data, then reacquire
    task automatic t_sync();
        int n;
        tx_nrz = 1'b1;
        wait_sync(1'b1, n);
        check("sync_gain", 1, rx_sync);
        repeat (4) begin
            @(posedge sym.valid);
            #1;
            check("idle_sym", IDLE_SYM, sym.data);
        end
        repeat (3 * HOLD) @(negedge core_clk_i);
        check("sync_kept", 1, rx_sync);
        tx_nrz = 1'b0;
        wait_sync(1'b0, n);
        check("hold_lo", 1, n > HOLD - 60);
        check("hold_hi", 1, n <= HOLD + 10);
        tx_nrz = 1'b1;
        wait_sync(1'b1, n);
        check("resync", 1, rx_sync);
    endtask : t_sync
    // five tries of idles and start pair, each one bit later, so one hits the boundary
    task automatic t_align();
        logic [20:0] pat;
        pat = {11'h7_ff, JK_FIRST, JK_SECOND};
        check("align_idle", 0, aligned);
        repeat (5) begin
            for (int i = 20; i >= 0; i--) begin
                tx_nrz = pat[i];
                @(negedge core_clk_i);
            end
        end
        tx_nrz = 1'b1;
        repeat (12) @(negedge core_clk_i);
        check("align_lock", 1, aligned);
        check("align_sync", 1, rx_sync);
    endtask : t_align
    initial begin
        t_seed();
        t_detect();
        t_sync();
        t_align();
        summarize();
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            summarize();
        end
    end
endmodule : fesl_line_code_tb_top
bind fesl_line_code fesl_line_code_sva chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .tx_line_o(tx_line_o), .rx_energy_i(rx_energy_i), .rx_link_pulse_i(rx_link_pulse_i),
    .signal_detect_o(signal_detect_o), .rx_sym_o(rx_sym_o), .rx_sync_o(rx_sync_o));
`default_nettype wire

// ---- src/fesl_line_code.sv ----
// transmit scrambler, nrzi and mlt-3 split; receive decode, descrambler and grouping
//
// Behaviour
// - transmit scrambler is a closed-loop 11-bit LFSR.
// - scrambled bit is encoder NRZ bit XOR scrambler output.
// - scrambler seed derives from the five-bit station address strap.
// - scrambled stream is NRZI coded, toggling level on each one.
// - NRZI ones alternate between two output rails, forming MLT-3.
// - only MLT-3 leaves the transmit pair; no binary output mode exists.
// - link pulses never assert signal detect.
// - received MLT-3 levels are turned into NRZI bits first.
// - NRZI converted to NRZ, transition means one, then descrambled.
// - received bits grouped into five-bit symbols for the PCS.
// - descrambler regenerates key; unscrambled bit is scrambled bit XOR key.
// - sync declared after twelve descrambled idle groups; unaligned symbols then output.
// - declaring sync starts a 722 us hold countdown.
// - idles spanning 58 bit times restart the hold countdown.
// - hold expiry drops sync, resets descrambler, restarts acquisition.
// - aligned flag sets after 11000 then 10001 seen as delivered groups; the boundary is never moved.
`timescale 1ns/1ps
`default_nettype none
module fesl_line_code #(
    parameter int unsigned HOLD_CYC = fesl_pkg::HOLD_CYC_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] station_address_strap_i,
    input wire logic tx_nrz_i,
    output fesl_pkg::fesl_mlt3_s tx_line_o,
    input wire fesl_pkg::fesl_mlt3_s rx_line_i,
    input wire logic rx_energy_i,
    input wire logic rx_link_pulse_i,
    output logic signal_detect_o,
    output fesl_pkg::fesl_sym_s rx_sym_o,
    output logic rx_sync_o,
    output logic rx_aligned_o
);
    import fesl_pkg::*;

    // data flow, one bit per clock in each direction:
    //   tx: nrz bit -> scramble -> nrzi -> two-rail mlt-3 -> registered rails
    //   rx: rails -> nrzi level -> nrz edge -> descramble -> 5-bit grouping
    // the two directions share no state; only the line closes the loop
    // rail coding: both low is the zero level, pos or neg high the outer levels
    // latency: a tx bit shows on the rails one edge after it is taken
    // the hold timer counts clocks, so its length scales with the clock rate
    // limitation: no bypass of scrambler or nrzi; only mlt-3 ever leaves
    // acquisition assumes idle traffic; data during acquisition only delays lock
    // symbol boundary is free-running; alignment is flagged, never enforced
    // signal detect is a plain filtered level, no timing qualification
    // all outputs come from flops, so downstream logic sees no glitches
    // reset is synchronous; every register takes its reset value on the same edge
    // strap is read at the load edge only; later changes have no effect

    // seed caught by a clocked load at reset release, never by the async path
    // trade-off: xor of an all-ones base never yields the dead all-zero state
    logic [10:0] seed;
    assign seed = SEED_BASE ^ {6'h00, station_address_strap_i};

    // transmit state
    // scrambler register; seeded once, then free-running
    logic [10:0] tx_lfsr_q, tx_lfsr_d;
    // nrzi line level and the mlt-3 polarity phase
    logic tx_nrzi_q, tx_nrzi_d;
    logic tx_phase_q, tx_phase_d;
    // low until the seed load edge has passed
    logic seeded_q, seeded_d;
    // registered rails, so the driver never sees a glitch
    fesl_mlt3_s tx_line_q, tx_line_d;
    logic scrambled_bit;

    // transmit path next state
    always_comb begin
        tx_lfsr_d = tx_lfsr_q;
        seeded_d = 1'b1;
        scrambled_bit = tx_nrz_i ^ tx_lfsr_q[TAP_HI];
        if (!seeded_q) begin
            tx_lfsr_d = seed;
        end else begin
            tx_lfsr_d = {tx_lfsr_q[9:0], tx_lfsr_q[TAP_HI] ^ tx_lfsr_q[TAP_LO]};
        end
        // nrzi: a one flips the level, a zero holds it
        tx_nrzi_d = tx_nrzi_q ^ scrambled_bit;
        tx_phase_d = tx_phase_q;
        tx_line_d = '0;
        // level high goes out on the rail picked by alternating phase
        if (tx_nrzi_d) begin
            tx_line_d.pos = ~tx_phase_q;
            tx_line_d.neg = tx_phase_q;
        end
        // phase turns when a high level ends, giving + 0 - 0
        if (tx_nrzi_q && !tx_nrzi_d) begin
            tx_phase_d = ~tx_phase_q;
        end
    end

    // transmit registers; reset clears line state to the zero level
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_lfsr_q <= LFSR_RST;
            tx_nrzi_q <= 1'b0;
            tx_phase_q <= 1'b0;
            seeded_q <= 1'b0;
            tx_line_q <= '0;
        end else begin
            tx_lfsr_q <= tx_lfsr_d;
            tx_nrzi_q <= tx_nrzi_d;
            tx_phase_q <= tx_phase_d;
            seeded_q <= seeded_d;
            tx_line_q <= tx_line_d;
        end
    end
    // rails straight from flops
    assign tx_line_o = tx_line_q;

    // receive state
    // previous nrzi level, for edge decoding
    logic rx_nrzi_q, rx_nrzi_d;
    // descrambler register, mirror of the transmit one
    logic [10:0] rx_lfsr_q, rx_lfsr_d;
    fesl_sync_e sync_q, sync_d;
    // run length of descrambled ones, saturating
    logic [5:0] ones_q, ones_d;
    // hold countdown in clocks; zero while unsynced
    logic [31:0] hold_q, hold_d;
    // free-running bit position inside the current group
    logic [2:0] bitcnt_q, bitcnt_d;
    logic [4:0] shift_q, shift_d;
    fesl_sym_s sym_q, sym_d;
    // last delivered group, for start-pair detection
    logic [4:0] prev_sym_q, prev_sym_d;
    logic aligned_q, aligned_d;
    logic sd_q, sd_d;
    logic rx_nrzi_bit, rx_nrz_bit, key_bit, unscrambled_bit;

    // receive path next state
    always_comb begin
        // line decode: any outer level is an nrzi one
        rx_nrzi_bit = rx_line_i.pos | rx_line_i.neg;
        rx_nrz_bit = rx_nrzi_bit ^ rx_nrzi_q;
        rx_nrzi_d = rx_nrzi_bit;
        // key runs self-synchronously off scrambled bits while unsynced
        key_bit = rx_lfsr_q[TAP_HI] ^ rx_lfsr_q[TAP_LO];
        unscrambled_bit = rx_nrz_bit ^ key_bit;
        rx_lfsr_d = {rx_lfsr_q[9:0], key_bit};
        sync_d = sync_q;
        ones_d = unscrambled_bit ? ((ones_q == 6'h3f) ? ones_q : ones_q + 6'h01) : 6'h00;
        hold_d = hold_q;
        // filter: pulses alone are not a carrier
        sd_d = rx_energy_i & ~rx_link_pulse_i;
        if (sync_q == FESL_UNSYNC) begin
            // load observed stream: a run of descrambled ones implies lock
            rx_lfsr_d = {rx_lfsr_q[9:0], ~rx_nrz_bit};
            if (32'(ones_d) >= SYNC_BITS) begin
                sync_d = FESL_SYNC;
                hold_d = HOLD_CYC;
            end
        // supervision: expiry first, then idle refresh, else count down
        end else if (hold_q == 32'h0000_0000) begin
            // expiry drops sync, reloads the descrambler and clears the ones run
            sync_d = FESL_UNSYNC;
            rx_lfsr_d = LFSR_RST;
            ones_d = 6'h00;
        end else if (32'(ones_d) >= HOLD_IDLE_BITS) begin
            hold_d = HOLD_CYC;
            ones_d = 6'h00;
        end else begin
            hold_d = hold_q - 32'h0000_0001;
        end
        // grouping runs free; the boundary is left to the downstream aligner
        shift_d = {shift_q[3:0], unscrambled_bit};
        bitcnt_d = (bitcnt_q == 3'd4) ? 3'd0 : bitcnt_q + 3'd1;
        // gate on next sync state, so no group leaves in the cycle sync drops
        sym_d.valid = (bitcnt_q == 3'd4) && (sync_d == FESL_SYNC);
        sym_d.data = shift_d;
        prev_sym_d = sym_d.valid ? shift_d : prev_sym_q;
        // start-pair watch; cleared whenever sync is lost
        aligned_d = aligned_q;
        if (sync_q != FESL_SYNC) begin
            aligned_d = 1'b0;
        end else if (sym_d.valid && prev_sym_q == JK_FIRST && shift_d == JK_SECOND) begin
            aligned_d = 1'b1;
        end
    end

    // receive registers; reset leaves the descrambler unsynced
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_nrzi_q <= 1'b0;
            rx_lfsr_q <= LFSR_RST;
            sync_q <= FESL_UNSYNC;
            ones_q <= ONES_RST;
            hold_q <= 32'h0000_0000;
            bitcnt_q <= 3'd0;
            shift_q <= 5'h00;
            sym_q <= '0;
            prev_sym_q <= 5'h00;
            aligned_q <= 1'b0;
            sd_q <= 1'b0;
        end else begin
            rx_nrzi_q <= rx_nrzi_d;
            rx_lfsr_q <= rx_lfsr_d;
            sync_q <= sync_d;
            ones_q <= ones_d;
            hold_q <= hold_d;
            bitcnt_q <= bitcnt_d;
            shift_q <= shift_d;
            sym_q <= sym_d;
            prev_sym_q <= prev_sym_d;
            aligned_q <= aligned_d;
            sd_q <= sd_d;
        end
    end

    // outputs straight from state
    assign rx_sym_o = sym_q;
    assign rx_sync_o = (sync_q == FESL_SYNC);
    assign rx_aligned_o = aligned_q;
    assign signal_detect_o = sd_q;
endmodule : fesl_line_code
`default_nettype wire

// ---- src/fesl_pkg.sv ----
// shared constants and carrier types for the 100 Mb/s line-coding path
package fesl_pkg;
    // clock rate, in MHz as printed for the symbol clock
    localparam int unsigned CLK_MHZ = 20;
    // scrambler geometry
    localparam int unsigned LFSR_W = 11;
    localparam int unsigned TAP_HI = 10;
    localparam int unsigned TAP_LO = 8;
    localparam logic [10:0] SEED_BASE = 11'h7_ff;
    localparam logic [10:0] LFSR_RST = 11'h7_ff;
    // receive grouping
    localparam int unsigned SYM_W = 5;
    localparam logic [4:0] IDLE_SYM = 5'h1_f;
    localparam logic [4:0] JK_FIRST = 5'h1_8;
    localparam logic [4:0] JK_SECOND = 5'h1_1;
    // descrambler acquisition and supervision
    localparam int unsigned SYNC_IDLES = 12;
    localparam int unsigned SYNC_BITS = SYNC_IDLES * SYM_W;
    localparam int unsigned HOLD_IDLE_BITS = 58;
    localparam int unsigned HOLD_US = 722;
    localparam int unsigned HOLD_CYC_DEF = HOLD_US * CLK_MHZ;
    localparam logic [5:0] ONES_RST = 6'h00;

    // three-level line value as two binary rails
    typedef struct packed {
        logic pos;
        logic neg;
    } fesl_mlt3_s;

    // five-bit symbol with its strobe
    typedef struct packed {
        logic valid;
        logic [4:0] data;
    } fesl_sym_s;

    typedef enum logic [1:0] {
        FESL_UNSYNC = 2'b00,
        FESL_SYNC = 2'b01
    } fesl_sync_e;
endpackage : fesl_pkg
